/* File: cbc_pkg.sv */
package cbc_pkg;

   localparam int CBC_NCH          = 16;
   localparam int CBC_CLK_HZ       = 20_000_000;
   localparam int CBC_TICK_MS      = 1000;
   localparam int CBC_TICK_CYCLES  = (CBC_CLK_HZ / 1000) * CBC_TICK_MS;

   localparam logic [7:0] CBC_OFF_CTRL     = 8'h00;
   localparam logic [7:0] CBC_OFF_STATUS   = 8'h04;
   localparam logic [7:0] CBC_OFF_THERM    = 8'h08;
   localparam logic [7:0] CBC_OFF_CELL_V   = 8'h0c;
   localparam logic [7:0] CBC_OFF_MB_TIMER = 8'h10;
   localparam logic [7:0] CBC_OFF_MB_V     = 8'h14;
   localparam logic [7:0] CBC_OFF_REMAIN   = 8'h18;
   localparam logic [1:0] CBC_OFF_CH_PAGE  = 2'b01;

   localparam int CBC_B_START     = 0;
   localparam int CBC_B_MPAUSE    = 1;
   localparam int CBC_B_THERM_EN  = 2;
   localparam int CBC_B_FSTOP_EN  = 3;
   localparam int CBC_B_ACTION    = 4;
   localparam int CBC_B_TSEL      = 8;
   localparam int CBC_B_TLOAD     = 12;

   localparam logic [7:0] CBC_TIME_INVALID = 8'hff;
   localparam logic [1:0] CBC_ACT_SHUTDOWN = 2'h2;
   localparam logic [1:0] CBC_RESP_OKAY    = 2'h0;
   localparam logic [1:0] CBC_RESP_SLVERR  = 2'h2;

   typedef struct packed {
      logic                 die_hot;
      logic                 die_cool;
      logic                 therm_hot;
      logic                 therm_clear;
      logic                 stack_low;
      logic                 aux_run;
      logic                 fault;
      logic [CBC_NCH-1:0]   cell_low;
   } cbc_sense_t;

   typedef struct packed {
      cbc_sense_t                 s1;
      cbc_sense_t                 s2;
      logic [31:0]                tick_cnt;
      logic                       tick;
      logic                       manual_pause;
      logic                       therm_en;
      logic                       fault_stop_en;
      logic [1:0]                 action;
      logic [3:0]                 tsel;
      logic [6:0]                 therm_cfg;
      logic [7:0]                 cell_stop_v;
      logic [7:0]                 mb_timer;
      logic [7:0]                 mb_stop_v;
      logic [7:0]                 remaining;
      logic [CBC_NCH-1:0][7:0]    ch_timer;
      logic [CBC_NCH-1:0][7:0]    ch_cnt;
      logic [CBC_NCH-1:0]         active;
      logic [CBC_NCH-1:0]         switches;
      logic                       started;
      logic                       run;
      logic                       die_p;
      logic                       therm_p;
      logic                       in_pause;
      logic                       tpd;
      logic                       done;
      logic                       abort;
      logic                       cb_used;
      logic                       module_running;
      logic                       module_done;
      logic                       mb_used;
      logic [7:0]                 mb_cnt;
      logic                       act_pend;
      logic                       pwr_req;
      logic [1:0]                 pwr_mode;
      logic                       aw_got;
      logic                       w_got;
      logic [7:0]                 awaddr;
      logic [31:0]                wdata;
      logic [3:0]                 wstrb;
      logic                       awready;
      logic                       wready;
      logic                       bvalid;
      logic [1:0]                 bresp;
      logic                       arready;
      logic                       rvalid;
      logic [31:0]                rdata;
      logic [1:0]                 rresp;
   } cbc_state_t;

endpackage : cbc_pkg

/* File: cbc_top.sv */
// Operation
// RULE1 - On start enable die sensors; any sensor hot pauses all channels, sets flags.
// RULE2 - Die pause resumes only when every sensor is below warning minus hysteresis.
// RULE3 - With thermistor pause enabled, a hot thermistor pauses all channels and sets flags.
// RULE4 - Thermistor pause resumes when all thermistors are below threshold plus cool-off.
// RULE5 - Host configures inputs, thresholds, starts protector, then sets enable and start.
// RULE6 - New thermistor thresholds apply after protector restart, without a new start.
// RULE7 - Pause turns all switches off, freezes timers, sets in-pause; resume continues.
// RULE8 - No fault abort of cell balancing while paused.
// RULE9 - Host manual pause bit pauses balancing like the thermal pauses.
// RULE10 - Non-zero stop voltage stops a channel on timer expiry or low voltage.
// RULE11 - Host programs stop voltage, starts undervoltage protector, then issues start.
// RULE12 - Fault stop enabled plus fault stops all channels, sets abort, leaves done clear.
// RULE13 - Done is set only when every channel met a timer or voltage stop.
// RULE14 - Start with all timers zero never balances and keeps done clear.
// RULE15 - Non-zero timers with all cells below stop voltage start, stop at once, set done.
// RULE16 - On completion request the selected power mode; wait for module done too.
// RULE17 - Time load copies the selected channel's remaining time to the readback.
// RULE18 - Readback shows the invalid code when balancing was never started or all zero.
// RULE19 - Readback is zero after expiry and the remaining time after a voltage stop.
// RULE20 - Module start drives the load pin as output and sets module running.
// RULE21 - Module ends with done on timer or low stack; without done on zero or fault.
// RULE22 - Module ignores pauses and checks stack voltage only while aux conversion runs.
// RULE23 - No switch turns on before the start command.
// RULE24 - Timers count down from a fixed time base derived from the core clock; the module timer counts up to its setting on that base.
module cbc_top
   import cbc_pkg::*;
#(
   parameter int P_TICK_CYCLES = CBC_TICK_CYCLES
) (
   input  wire logic                I_CLOCK,
   input  wire logic                I_RESET_N,
   input  wire logic                I_AWVALID,
   output      logic                O_AWREADY,
   input  wire logic [7:0]          I_AWADDR,
   input  wire logic                I_WVALID,
   output      logic                O_WREADY,
   input  wire logic [31:0]         I_WDATA,
   input  wire logic [3:0]          I_WSTRB,
   output      logic                O_BVALID,
   input  wire logic                I_BREADY,
   output      logic [1:0]          O_BRESP,
   input  wire logic                I_ARVALID,
   output      logic                O_ARREADY,
   input  wire logic [7:0]          I_ARADDR,
   output      logic                O_RVALID,
   input  wire logic                I_RREADY,
   output      logic [31:0]         O_RDATA,
   output      logic [1:0]          O_RRESP,
   input  wire cbc_sense_t          I_SENSE,
   output      logic [CBC_NCH-1:0]  O_BALANCE_SWITCH,
   output      logic                O_DIE_SENSE_EN,
   output      logic                O_MODULE_LOAD_OUT,
   output      logic                O_MODULE_LOAD_OE,
   output      logic                O_POWER_REQ,
   output      logic [1:0]          O_POWER_MODE,
   output      logic [6:0]          O_THERM_PAUSE_CONFIG,
   output      logic [7:0]          O_CELL_STOP_VOLTAGE,
   output      logic [7:0]          O_MODULE_STOP_VOLTAGE
);

   logic [1:0]  rst_sync_reg;
   logic        rst_n;
   cbc_state_t  s_reg;
   cbc_state_t  s_next;
   logic        wr_start;
   logic        wr_tload;
   logic        paused;

   assign rst_n = rst_sync_reg[1];

   // Register images as seen by software.
   function automatic logic [31:0] reg_image(input cbc_state_t s, input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0;
      if (a[7:6] == CBC_OFF_CH_PAGE) begin
         v[7:0] = s.ch_timer[a[5:2]];
      end else begin
         case (a)
            CBC_OFF_CTRL: begin
               v[CBC_B_MPAUSE]           = s.manual_pause;
               v[CBC_B_THERM_EN]         = s.therm_en;
               v[CBC_B_FSTOP_EN]         = s.fault_stop_en;
               v[CBC_B_ACTION+:2]        = s.action;
               v[CBC_B_TSEL+:4]          = s.tsel;
            end
            CBC_OFF_STATUS:   v[6:0] = {s.module_done, s.module_running, s.abort, s.done,
                                        s.tpd, s.in_pause, s.run};
            CBC_OFF_THERM:    v[6:0] = s.therm_cfg;
            CBC_OFF_CELL_V:   v[7:0] = s.cell_stop_v;
            CBC_OFF_MB_TIMER: v[7:0] = s.mb_timer;
            CBC_OFF_MB_V:     v[7:0] = s.mb_stop_v;
            CBC_OFF_REMAIN:   v[7:0] = s.remaining;
            default:          v = 32'h0;
         endcase
      end
      return v;
   endfunction : reg_image

   function automatic logic addr_ok(input logic [7:0] a);
      return (a[7:6] == CBC_OFF_CH_PAGE) || (a <= CBC_OFF_REMAIN && a[1:0] == 2'b00);
   endfunction : addr_ok

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] st);
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            o[b*8+:8] = d[b*8+:8];
         end
      end
      return o;
   endfunction : wmerge

   always_comb begin
      logic [31:0] wv;
      logic        wr_do;
      logic        mb_end_ok;
      wv       = wmerge(reg_image(s_reg, s_reg.awaddr), s_reg.wdata, s_reg.wstrb);
      wr_do    = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
      mb_end_ok = 1'b0;
      s_next   = s_reg;
      wr_start = 1'b0;
      wr_tload = 1'b0;
      s_next.s1 = I_SENSE;
      s_next.s2 = s_reg.s1;
      s_next.pwr_req = 1'b0;
      // Free-running time base from the core clock.
      s_next.tick = (s_reg.tick_cnt == 32'(P_TICK_CYCLES - 1)); // RULE24
      s_next.tick_cnt = s_next.tick ? 32'h0 : s_reg.tick_cnt + 32'h1; // RULE24

      // Bus slave: address and data in either order, response after both.
      if (I_AWVALID && s_reg.awready) begin
         s_next.aw_got = 1'b1;
         s_next.awaddr = I_AWADDR;
      end
      if (I_WVALID && s_reg.wready) begin
         s_next.w_got = 1'b1;
         s_next.wdata = I_WDATA;
         s_next.wstrb = I_WSTRB;
      end
      if (s_reg.bvalid && I_BREADY) begin
         s_next.bvalid = 1'b0;
      end
      if (wr_do) begin
         s_next.aw_got = 1'b0;
         s_next.w_got  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = addr_ok(s_reg.awaddr) ? CBC_RESP_OKAY : CBC_RESP_SLVERR;
         if (s_reg.awaddr[7:6] == CBC_OFF_CH_PAGE) begin
            s_next.ch_timer[s_reg.awaddr[5:2]] = wv[7:0];
         end else begin
            case (s_reg.awaddr)
               CBC_OFF_CTRL: begin
                  wr_start              = wv[CBC_B_START];
                  wr_tload              = wv[CBC_B_TLOAD]; // RULE17
                  s_next.manual_pause   = wv[CBC_B_MPAUSE]; // RULE9
                  s_next.therm_en       = wv[CBC_B_THERM_EN];
                  s_next.fault_stop_en  = wv[CBC_B_FSTOP_EN];
                  s_next.action         = wv[CBC_B_ACTION+:2];
                  s_next.tsel           = wv[CBC_B_TSEL+:4];
               end
               CBC_OFF_THERM:    s_next.therm_cfg   = wv[6:0]; // RULE6
               CBC_OFF_CELL_V:   s_next.cell_stop_v = wv[7:0];
               CBC_OFF_MB_TIMER: s_next.mb_timer    = wv[7:0];
               CBC_OFF_MB_V:     s_next.mb_stop_v   = wv[7:0];
               default:          s_next.bresp       = s_next.bresp;
            endcase
         end
      end
      if (I_ARVALID && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = reg_image(s_reg, I_ARADDR);
         s_next.rresp  = addr_ok(I_ARADDR) ? CBC_RESP_OKAY : CBC_RESP_SLVERR;
      end else if (s_reg.rvalid && I_RREADY) begin
         s_next.rvalid = 1'b0;
      end

      // Balancing engine.
      paused = s_reg.die_p || s_reg.therm_p || s_reg.manual_pause; // RULE9
      if (wr_start) begin
         s_next.started  = 1'b1;
         s_next.ch_cnt   = s_reg.ch_timer;
         for (int i = 0; i < CBC_NCH; i++) begin
            s_next.active[i] = (s_reg.ch_timer[i] != 8'h0); // RULE14
         end
         s_next.cb_used  = |s_next.active;
         s_next.run      = s_next.cb_used; // RULE14
         s_next.done     = 1'b0;
         s_next.abort    = 1'b0;
         s_next.tpd      = 1'b0;
         s_next.die_p    = 1'b0;
         s_next.therm_p  = 1'b0;
         s_next.mb_used  = (s_reg.mb_timer != 8'h0);
         s_next.module_running   = s_next.mb_used; // RULE20 RULE21
         s_next.module_done  = 1'b0; // RULE21
         s_next.mb_cnt   = 8'h0;
         s_next.act_pend = s_next.cb_used || s_next.mb_used;
      end else begin
         if (s_reg.run && s_reg.s2.die_hot) begin
            s_next.die_p = 1'b1; // RULE1
         end else if (s_reg.s2.die_cool) begin
            s_next.die_p = 1'b0; // RULE2
         end
         if (s_reg.run && s_reg.therm_en && s_reg.s2.therm_hot) begin
            s_next.therm_p = 1'b1; // RULE3
         end else if (s_reg.s2.therm_clear || !s_reg.therm_en) begin
            s_next.therm_p = 1'b0; // RULE4
         end
         if (s_reg.run && (s_reg.s2.die_hot || (s_reg.therm_en && s_reg.s2.therm_hot))) begin
            s_next.tpd = 1'b1; // RULE1 RULE3
         end
         if (s_reg.run) begin
            if (s_reg.fault_stop_en && s_reg.s2.fault && !paused) begin // RULE8
               s_next.active = '0; // RULE12
               s_next.run    = 1'b0;
               s_next.abort  = 1'b1;
            end else begin
               for (int i = 0; i < CBC_NCH; i++) begin
                  if (s_reg.active[i]) begin
                     if (s_reg.tick && !paused) begin // RULE7
                        s_next.ch_cnt[i] = s_reg.ch_cnt[i] - 8'h1;
                        if (s_reg.ch_cnt[i] == 8'h1) begin
                           s_next.active[i] = 1'b0; // RULE10 RULE19
                        end
                     end
                     if (s_reg.cell_stop_v != 8'h0 && s_reg.s2.cell_low[i]) begin
                        s_next.ch_cnt[i] = s_reg.ch_cnt[i]; // RULE19
                        s_next.active[i] = 1'b0; // RULE10 RULE15
                     end
                  end
               end
               if (s_next.active == '0) begin
                  s_next.run  = 1'b0;
                  s_next.done = 1'b1; // RULE13 RULE15
               end
            end
         end
         // Module path has no pause input at all.
         if (s_reg.module_running) begin // RULE22
            if (s_reg.fault_stop_en && s_reg.s2.fault) begin
               s_next.module_running = 1'b0; // RULE21
            end else begin
               if (s_reg.tick) begin
                  s_next.mb_cnt = s_reg.mb_cnt + 8'h1;
                  mb_end_ok = (s_next.mb_cnt >= s_reg.mb_timer); // RULE21
               end
               if (s_reg.s2.aux_run && s_reg.s2.stack_low && s_reg.mb_stop_v != 8'h0) begin
                  mb_end_ok = 1'b1; // RULE22
               end
               if (mb_end_ok) begin
                  s_next.module_running  = 1'b0;
                  s_next.module_done = 1'b1; // RULE21
               end
            end
         end
         if (s_reg.act_pend && !s_next.run && !s_next.module_running) begin
            s_next.act_pend = 1'b0;
            s_next.pwr_req  = (!s_reg.cb_used || s_next.done)
                              && (!s_reg.mb_used || s_next.module_done); // RULE16
            s_next.pwr_mode = s_reg.action; // RULE16
         end
      end
      if (wr_tload) begin
         s_next.remaining = (!s_reg.started || !s_reg.cb_used) ? CBC_TIME_INVALID // RULE18
                            : s_reg.ch_cnt[s_next.tsel]; // RULE17 RULE19
      end
      s_next.in_pause = s_next.run && (s_next.die_p || s_next.therm_p
                                       || s_next.manual_pause); // RULE7
      s_next.switches = (s_next.run && !s_next.in_pause) ? s_next.active : '0; // RULE7 RULE23
      s_next.awready  = !s_next.aw_got && !s_next.bvalid;
      s_next.wready   = !s_next.w_got && !s_next.bvalid;
      s_next.arready  = !s_next.rvalid;
   end

   always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign O_AWREADY             = s_reg.awready;
   assign O_WREADY              = s_reg.wready;
   assign O_BVALID              = s_reg.bvalid;
   assign O_BRESP               = s_reg.bresp;
   assign O_ARREADY             = s_reg.arready;
   assign O_RVALID              = s_reg.rvalid;
   assign O_RDATA               = s_reg.rdata;
   assign O_RRESP               = s_reg.rresp;
   assign O_BALANCE_SWITCH      = s_reg.switches;
   assign O_DIE_SENSE_EN        = s_reg.started; // RULE1
   assign O_MODULE_LOAD_OUT     = s_reg.module_running; // RULE20
   assign O_MODULE_LOAD_OE      = s_reg.module_running; // RULE20
   assign O_POWER_REQ           = s_reg.pwr_req;
   assign O_POWER_MODE          = s_reg.pwr_mode;
   assign O_THERM_PAUSE_CONFIG  = s_reg.therm_cfg;
   assign O_CELL_STOP_VOLTAGE   = s_reg.cell_stop_v;
   assign O_MODULE_STOP_VOLTAGE = s_reg.mb_stop_v;

   default clocking cb_clk @(posedge I_CLOCK);
   endclocking
   default disable iff (!rst_n);

   sequence seq_die_hot;
      s_reg.run && s_reg.s2.die_hot && !wr_start;
   endsequence
   sequence seq_therm_hot;
      s_reg.run && s_reg.therm_en && s_reg.s2.therm_hot && !wr_start;
   endsequence
   sequence seq_zero_start;
      wr_start && (s_reg.ch_timer == '0);
   endsequence

   AST_NO_SWITCH_BEFORE_START: assert property (!s_reg.started |-> s_reg.switches == '0) // RULE23
      else $error("switch on before start");

   AST_DIE_PAUSE: assert property (seq_die_hot |=> s_reg.tpd && s_reg.die_p) // RULE1
      else $error("die pause not entered");

   AST_DIE_RESUME: assert property (s_reg.die_p && s_reg.s2.die_cool && !s_reg.s2.die_hot // RULE2
         && !wr_start |=> !s_reg.die_p)
      else $error("die pause not left");

   AST_THERM_PAUSE: assert property (seq_therm_hot |=> s_reg.therm_p && s_reg.tpd) // RULE3
      else $error("thermistor pause not entered");

   AST_THERM_RESUME: assert property (s_reg.therm_p && s_reg.s2.therm_clear // RULE4
         && !(s_reg.run && s_reg.s2.therm_hot) && !wr_start |=> !s_reg.therm_p)
      else $error("thermistor pause not left");

   AST_PAUSE_FREEZE: assert property (s_reg.in_pause && !wr_start // RULE7
         |-> s_reg.switches == '0 ##1 s_reg.ch_cnt == $past(s_reg.ch_cnt))
      else $error("timers moved in pause");

   AST_PAUSE_NO_ABORT: assert property (s_reg.run && paused && !wr_start |=> !s_reg.abort) // RULE8
      else $error("abort while paused");

   AST_FAULT_ABORT: assert property (s_reg.run && s_reg.fault_stop_en && s_reg.s2.fault // RULE12
         && !paused && !wr_start |=> !s_reg.run && s_reg.abort && !s_reg.done)
      else $error("fault abort wrong");

   AST_DONE_ALL: assert property ($rose(s_reg.done) |-> s_reg.active == '0 && !s_reg.abort) // RULE13
      else $error("done with channel active");

   AST_ZERO_START: assert property (seq_zero_start |=> !s_reg.run && !s_reg.done [*2]) // RULE14
      else $error("zero start balanced");

   AST_MODULE_START: assert property (wr_start && s_reg.mb_timer != 8'h0 // RULE20
         |=> s_reg.module_running && O_MODULE_LOAD_OE && O_MODULE_LOAD_OUT)
      else $error("module not started");

   AST_TIME_INVALID: assert property (wr_tload && !s_reg.started // RULE18
         |=> s_reg.remaining == CBC_TIME_INVALID)
      else $error("invalid code missing");

   AST_POWER_MODE: assert property (s_reg.pwr_req |-> s_reg.pwr_mode == $past(s_reg.action) // RULE16
         && !s_reg.run && !s_reg.module_running)
      else $error("power request wrong");

endmodule : cbc_top

/* File: cbc_host_model.sv */
module cbc_host_model
   import cbc_pkg::*;
(
   input  wire logic        i_clk,
   output      logic        o_awvalid,
   input  wire logic        i_awready,
   output      logic [7:0]  o_awaddr,
   output      logic        o_wvalid,
   input  wire logic        i_wready,
   output      logic [31:0] o_wdata,
   output      logic [3:0]  o_wstrb,
   input  wire logic        i_bvalid,
   output      logic        o_bready,
   input  wire logic [1:0]  i_bresp,
   output      logic        o_arvalid,
   input  wire logic        i_arready,
   output      logic [7:0]  o_araddr,
   input  wire logic        i_rvalid,
   output      logic        o_rready,
   input  wire logic [31:0] i_rdata,
   input  wire logic [1:0]  i_rresp
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
      {o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
   end
   // Address and data are offered together and each is released once taken.
   task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      o_awaddr  <= a;
      o_wdata   <= d;
      o_wstrb   <= 4'hf;
      o_awvalid <= 1'b1;
      o_wvalid  <= 1'b1;
      o_bready  <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_awvalid && i_awready) o_awvalid <= 1'b0;
         if (o_wvalid && i_wready) o_wvalid <= 1'b0;
      end while (i_bvalid !== 1'b1);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask : write
   task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      o_araddr  <= a;
      o_arvalid <= 1'b1;
      o_rready  <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_arvalid && i_arready) o_arvalid <= 1'b0;
      end while (i_rvalid !== 1'b1);
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
   endtask : read
endmodule : cbc_host_model

/* File: cell_balance_controller_bench.sv */
module cell_balance_controller_bench import cbc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 8;
   logic        clk = 1'b0, rst_n = 1'b0;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, die_en, ld_out, ld_oe, preq;
   logic [7:0]  awaddr, araddr, csv, msv;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs, pmode;
   logic [6:0]  tcfg;
   logic [15:0] sw;
   cbc_sense_t  sense = '0;
   int          miscompares = 0, checked = 0, preqs = 0;
   always #25 clk = ~clk;
   always @(negedge clk) if (preq === 1'b1) preqs++;
   cbc_top #(.P_TICK_CYCLES(TK)) cbc_top_i (.I_CLOCK(clk), .I_RESET_N(rst_n),
      .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid),
      .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid),
      .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
      .I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata),
      .O_RRESP(rresp), .I_SENSE(sense), .O_BALANCE_SWITCH(sw), .O_DIE_SENSE_EN(die_en),
      .O_MODULE_LOAD_OUT(ld_out), .O_MODULE_LOAD_OE(ld_oe), .O_POWER_REQ(preq),
      .O_POWER_MODE(pmode), .O_THERM_PAUSE_CONFIG(tcfg), .O_CELL_STOP_VOLTAGE(csv),
      .O_MODULE_STOP_VOLTAGE(msv));
   cbc_host_model cbc_host_model_i (.i_clk(clk), .o_awvalid(awvalid), .i_awready(awready),
      .o_awaddr(awaddr), .o_wvalid(wvalid), .i_wready(wready), .o_wdata(wdata),
      .o_wstrb(wstrb), .i_bvalid(bvalid), .o_bready(bready), .i_bresp(bresp),
      .o_arvalid(arvalid), .i_arready(arready), .o_araddr(araddr), .i_rvalid(rvalid),
      .o_rready(rready), .i_rdata(rdata), .i_rresp(rresp));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cbc_host_model_i.write(a, d, rs);
      chk("write response", {30'h0, rs}, {30'h0, CBC_RESP_OKAY});
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      cbc_host_model_i.read(a, rv, rs);
      chk(nm, rv, e);
   endtask : rd
   // Polls the status word until the masked bits match, with a bounded count.
   task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
      int n = 0;
      cbc_host_model_i.read(CBC_OFF_STATUS, rv, rs);
      while ((rv & m) !== v && n < 100) begin
         cbc_host_model_i.read(CBC_OFF_STATUS, rv, rs);
         n++;
      end
   endtask : wait_st
   task automatic give_verdict;
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      wr(8'h40, 32'h3);
      wr(8'h44, 32'ha);
      wr(CBC_OFF_CTRL, 32'h1100);
      chk("switches before start", {16'h0, sw}, 32'h0);
      rd("remaining never started", CBC_OFF_REMAIN, 32'hff);
      rd("status idle", CBC_OFF_STATUS, 32'h0);
      wr(CBC_OFF_CTRL, 32'h21);
      repeat (2) @(posedge clk);
      chk("switches after start", {15'h0, die_en, sw}, 32'h10003);
      wr(CBC_OFF_CTRL, 32'h22);
      wait_st(32'h2, 32'h2);
      chk("switches in manual pause", {16'h0, sw}, 32'h0);
      repeat (80) @(posedge clk);
      wr(CBC_OFF_CTRL, 32'h20);
      repeat (4) @(posedge clk);
      chk("switches after pause", {16'h0, sw}, 32'h3);
      @(posedge clk);
      sense.die_hot <= 1'b1;
      wait_st(32'h6, 32'h6);
      chk("switches in die pause", {16'h0, sw}, 32'h0);
      sense.die_hot <= 1'b0;
      repeat (30) @(posedge clk);
      rd("pause held in hysteresis", CBC_OFF_STATUS, 32'h7);
      sense.die_cool <= 1'b1;
      wait_st(32'h8, 32'h8);
      chk("status done", rv, 32'hc);
      chk("power requests", preqs, 1);
      chk("power mode", {30'h0, pmode}, {30'h0, CBC_ACT_SHUTDOWN});
      wr(CBC_OFF_CTRL, 32'h1020);
      rd("remaining after expiry", CBC_OFF_REMAIN, 32'h0);
      wr(CBC_OFF_CELL_V, 32'h40);
      wr(CBC_OFF_THERM, 32'h35);
      wr(8'h40, 32'h32);
      wr(8'h44, 32'h32);
      chk("protector copies", {17'h0, tcfg, csv}, 32'h3540);
      wr(CBC_OFF_CTRL, 32'h5);
      sense.cell_low[1] <= 1'b1;
      repeat (6) @(posedge clk);
      chk("voltage stop one channel", {16'h0, sw}, 32'h1);
      sense.therm_hot <= 1'b1;
      wait_st(32'h6, 32'h6);
      chk("switches in thermistor pause", {16'h0, sw}, 32'h0);
      sense.therm_hot <= 1'b0;
      repeat (30) @(posedge clk);
      chk("still paused", {16'h0, sw}, 32'h0);
      sense.therm_clear <= 1'b1;
      wait_st(32'h2, 32'h0);
      chk("resumed", {16'h0, sw}, 32'h1);
      wr(CBC_OFF_CTRL, 32'h1105);
      cbc_host_model_i.read(CBC_OFF_REMAIN, rv, rs);
      chk("remaining after voltage stop", rv inside {32'h31, 32'h32}, 1);
      sense <= '0;
      wr(CBC_OFF_CTRL, 32'h9);
      wr(CBC_OFF_CTRL, 32'hb);
      sense.fault <= 1'b1;
      repeat (8) @(posedge clk);
      rd("no abort in pause", CBC_OFF_STATUS, 32'h3);
      wr(CBC_OFF_CTRL, 32'h9);
      wait_st(32'h10, 32'h10);
      chk("fault abort", {rv[15:0], sw}, 32'h100000);
      sense <= '{cell_low: '1, default: 1'b0};
      wr(CBC_OFF_CTRL, 32'h1);
      wait_st(32'h8, 32'h8);
      chk("immediate voltage done", rv, 32'h8);
      wr(CBC_OFF_CTRL, 32'h1000);
      rd("remaining kept", CBC_OFF_REMAIN, 32'h32);
      wr(8'h40, 32'h0);
      wr(8'h44, 32'h0);
      sense <= '0;
      wr(CBC_OFF_CTRL, 32'h1);
      repeat (6) @(posedge clk);
      rd("zero start status", CBC_OFF_STATUS, 32'h0);
      wr(CBC_OFF_CTRL, 32'h1000);
      rd("remaining zero start", CBC_OFF_REMAIN, 32'hff);
      wr(CBC_OFF_MB_TIMER, 32'h3);
      wr(CBC_OFF_MB_V, 32'h20);
      sense.aux_run <= 1'b1;
      wr(CBC_OFF_CTRL, 32'h3);
      wait_st(32'h20, 32'h20);
      chk("module load pin", {ld_oe, ld_out, 8'h0, msv}, 32'h30020);
      wait_st(32'h40, 32'h40);
      chk("module done despite pause", {rv[7:4], 2'b0, ld_oe}, 32'h20);
      chk("power requests total", preqs, 3);
      cbc_host_model_i.write(8'h30, 32'h1, rs);
      chk("unmapped write", {30'h0, rs}, {30'h0, CBC_RESP_SLVERR});
      cbc_host_model_i.read(8'h30, rv, rs);
      chk("unmapped read", {rs, rv[29:0]}, {CBC_RESP_SLVERR, 30'h0});
      give_verdict();
   end
endmodule : cell_balance_controller_bench
